// ---- bench/gpio_expander_chk.sv ----
// Purpose: Port-level timing checks for the serial port expander
// Assumes: SDA_IN carries the resolved bus level
// Notes:   Bound into gpio_expander_i2c after the module
`timescale 1ns/10ps
`default_nettype none
module gpio_expander_chk (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic LINK_CLK,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    input wire logic PORT_PIN_ZERO_OUT,
    input wire logic PORT_PIN_ONE_OUT,
    input wire logic PORT_PIN_TWO_OUT,
    input wire logic PORT_PIN_THREE_OUT,
    input wire logic PORT_PIN_ZERO_OE_N,
    input wire logic PORT_PIN_ONE_OE_N,
    input wire logic PORT_PIN_TWO_OE_N,
    input wire logic PORT_PIN_THREE_OE_N
);
    wire  [7:0] pins;
    logic [5:0] age_r;
    // Pin drive state, enables in the upper half
    assign pins = {PORT_PIN_THREE_OE_N, PORT_PIN_TWO_OE_N, PORT_PIN_ONE_OE_N, PORT_PIN_ZERO_OE_N,
                   PORT_PIN_THREE_OUT, PORT_PIN_TWO_OUT, PORT_PIN_ONE_OUT, PORT_PIN_ZERO_OUT};
    // Age since SDA was last pulled; register writes only land near an ack
    always_ff @(posedge CLK) begin
        if (!RSTN || !SDA_OE_N) age_r <= 6'h00;
        else if (age_r != 6'h3F) age_r <= age_r + 6'h01;
    end
    // Bus conditions as seen on the resolved lines
    sequence start_s; SCL_IN && $fell(SDA_IN); endsequence
    sequence stop_s; SCL_IN && $rose(SDA_IN); endsequence
    rst_pins_a: assert property (@(posedge CLK) disable iff (!RSTN) $rose(RSTN) |-> pins == 8'hFF)
        else $error("pins not released and high after reset");
    link_rst_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) $rose(RSTN) |-> SDA_OE_N)
        else $error("SDA pulled after reset");
    sda_low_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) !SDA_OE_N |-> !SDA_OUT)
        else $error("SDA driven high");
    sda_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) SCL_IN [*6] |-> $stable(SDA_OE_N))
        else $error("SDA drive changed while SCL high");
    sda_turn_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) $changed(SDA_OE_N) |->
        !SCL_IN && ($past(SCL_IN, 3) || $past(SCL_IN, 4) || $past(SCL_IN, 5) || $past(SCL_IN, 6)))
        else $error("SDA drive changed away from SCL fall");
    pin_chg_a: assert property (@(posedge CLK) disable iff (!RSTN) $changed(pins) |-> age_r < 6'h10)
        else $error("pin drive changed without a written byte");
    start_rel_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) start_s |-> SDA_OE_N [*8])
        else $error("SDA pulled right after start");
    stop_rel_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN) stop_s |-> SDA_OE_N [*8])
        else $error("SDA pulled right after stop");
endmodule : gpio_expander_chk
bind gpio_expander_i2c gpio_expander_chk u_chk (
    .CLK(CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .PORT_PIN_ZERO_OUT(PORT_PIN_ZERO_OUT), .PORT_PIN_ONE_OUT(PORT_PIN_ONE_OUT),
    .PORT_PIN_TWO_OUT(PORT_PIN_TWO_OUT), .PORT_PIN_THREE_OUT(PORT_PIN_THREE_OUT),
    .PORT_PIN_ZERO_OE_N(PORT_PIN_ZERO_OE_N), .PORT_PIN_ONE_OE_N(PORT_PIN_ONE_OE_N),
    .PORT_PIN_TWO_OE_N(PORT_PIN_TWO_OE_N), .PORT_PIN_THREE_OE_N(PORT_PIN_THREE_OE_N)
);
`default_nettype wire

// ---- bench/i2c_master_model.sv ----
// Purpose: Behavioural bus controller for the port expander
// Assumes: sda is the wired-AND level with pull-up
// Notes:   SCL stands high between frames
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
    input  wire logic       clk,
    input  wire logic       sda,
    output var  logic       scl_o,
    output var  logic       sda_o,
    output var  logic       rx_stb,
    output var  logic [8:0] rx_word
);
    localparam int Q = 8;
    logic [8:0] w;
    // Idle bus at time zero
    initial begin
        scl_o   = 1'b1;
        sda_o   = 1'b1;
        rx_stb  = 1'b0;
        rx_word = 9'h000;
    end
    // Quarter bit, changes land just after a falling edge
    task automatic wt;
        repeat (Q) @(negedge clk);
    endtask : wt
    // Start or repeated start, only from an idle or owned bus
    task automatic start;
        sda_o = 1'b1;
        wt;
        scl_o = 1'b1;
        wt;
        sda_o = 1'b0;
        wt;
        scl_o = 1'b0;
        wt;
    endtask : start
    task automatic stop;
        sda_o = 1'b0;
        wt;
        scl_o = 1'b1;
        wt;
        sda_o = 1'b1;
        wt;
    endtask : stop
    // Eight bits then the ack slot; a 1 releases SDA so the far side can drive
    task automatic xfer(input logic [8:0] tx);
        for (int i = 8; i >= 0; i--) begin
            sda_o = tx[i];
            wt;
            scl_o = 1'b1;
            wt;
            w[i] = sda;
            wt;
            scl_o = 1'b0;
            wt;
        end
        rx_word = w;
        rx_stb  = 1'b1;
        @(negedge clk);
        rx_stb  = 1'b0;
    endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the serial port expander
// Assumes: Bus results are checked in order from a queue
// Notes:   Pins modelled as following the outside level ext when released
`include "gpio_expander_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       CLK, RSTN, LINK_CLK, CE, scl, sda_m, rx_stb;
    logic [8:0] rx_word;
    logic [3:0] ext, m_out, m_pol, m_dir;
    logic [6:0] fa;
    logic [31:0] rnd;
    logic [8:0] exp_q[$];
    int         err_count, tests_run;
    wire  [3:0] pout, poe, lvl;
    wire        sda_bus, sda_oe_n, sda_out;
    // Wired-AND SDA; released pins follow the outside level
    assign sda_bus = sda_m & (sda_oe_n | sda_out);
    assign lvl     = (poe & ext) | (~poe & pout);
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // Link clock, unrelated phase
    initial begin
        LINK_CLK = 1'b0;
        #7;
        forever #15 LINK_CLK = ~LINK_CLK;
    end
    gpio_expander_i2c DUT (
        .CLK(CLK), .RSTN(RSTN), .CE(CE), .LINK_CLK(LINK_CLK), .SCL_IN(scl), .SDA_IN(sda_bus),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .PORT_PIN_ZERO_IN(lvl[0]), .PORT_PIN_ZERO_OUT(pout[0]), .PORT_PIN_ZERO_OE_N(poe[0]),
        .PORT_PIN_ONE_IN(lvl[1]), .PORT_PIN_ONE_OUT(pout[1]), .PORT_PIN_ONE_OE_N(poe[1]),
        .PORT_PIN_TWO_IN(lvl[2]), .PORT_PIN_TWO_OUT(pout[2]), .PORT_PIN_TWO_OE_N(poe[2]),
        .PORT_PIN_THREE_IN(lvl[3]), .PORT_PIN_THREE_OUT(pout[3]), .PORT_PIN_THREE_OE_N(poe[3])
    );
    i2c_master_model m (
        .clk(CLK), .sda(sda_bus), .scl_o(scl), .sda_o(sda_m), .rx_stb(rx_stb), .rx_word(rx_word)
    );
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // Expected read byte; unused upper bits read as ones, polarity as zeros
    function automatic logic [7:0] ev(input logic [1:0] r);
        case (r)
            `GX_REG_INPUT:    return {4'hF, ((m_dir & ext) | (~m_dir & m_out)) ^ m_pol};
            `GX_REG_OUTPUT:   return {4'hF, m_out};
            `GX_REG_POLARITY: return {4'h0, m_pol};
            default:          return {4'hF, m_dir};
        endcase
    endfunction : ev
    task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t bus word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t pin drive %h expected %h", $time, got, exp);
        end
    endtask : chk_pin
    // Byte sent by the controller, device answer noted
    task automatic bw(input logic [7:0] b, input logic a);
        exp_q.push_back({b, a});
        m.xfer({b, 1'b1});
    endtask : bw
    // Byte read back, controller answers with mack
    task automatic br(input logic [7:0] e, input logic mack);
        exp_q.push_back({e, mack});
        m.xfer({8'hFF, mack});
    endtask : br
    task automatic rst;
        RSTN = 1'b0;
        repeat (8) @(negedge CLK);
        RSTN  = 1'b1;
        m_out = `GX_OUT_RST;
        m_pol = `GX_POL_RST;
        m_dir = `GX_DIR_RST;
        repeat (8) @(negedge CLK);
    endtask : rst
    // Bounded wait for the direction to settle, then compare; released OUT is masked
    task automatic chk_pins;
        int n;
        n = 0;
        while (poe !== m_dir && n < 100) begin
            @(negedge CLK);
            n++;
        end
        chk_pin({poe, pout | m_dir}, {m_dir, m_out | m_dir});
    endtask : chk_pins
    task automatic wr(input logic [1:0] r, input logic [7:0] d);
        m.start;
        bw({`GX_DEV_ADDR, 1'b0}, 1'b0);
        bw({d[7:2], r}, 1'b0);
        bw(~d, 1'b0);
        bw(d, 1'b0);
        m.stop;
        case (r)
            `GX_REG_OUTPUT:   m_out = d[3:0];
            `GX_REG_POLARITY: m_pol = d[3:0];
            `GX_REG_DIRECTION: m_dir = d[3:0];
            default: ;
        endcase
    endtask : wr
    // Optional selection, repeated start, two reads of the same register
    task automatic rd(input logic [1:0] r, input logic setp);
        logic [7:0] e;
        e = ev(r);
        if (setp) begin
            m.start;
            bw({`GX_DEV_ADDR, 1'b0}, 1'b0);
            bw({rnd[7:2], r}, 1'b0);
        end
        m.start;
        bw({`GX_DEV_ADDR, 1'b1}, 1'b0);
        br(e, 1'b0);
        br(e, 1'b1);
        m.stop;
    endtask : rd
    task automatic results;
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Oldest note against each bus result
    always @(posedge rx_stb) begin
        if (exp_q.size() != 0) chk_word(rx_word, exp_q.pop_front());
        else begin
            err_count++;
            $display("[ERR] %0t bus word with no note", $time);
        end
    end
    // Main sequence, inputs change on falling edges
    initial begin
        CE   = 1'b1;
        ext  = 4'hF;
        rnd  = 32'h8211_65b3;
        rst;
        chk_pins;
        for (int r = 0; r < 4; r++) rd(2'(r), r != 0);
        // Frozen block: bus ignored, direction write must not land
        CE = 1'b0;
        repeat (4) @(negedge CLK);
        m.start;
        bw({`GX_DEV_ADDR, 1'b0}, 1'b1);
        bw(8'h03, 1'b1);
        bw(8'h00, 1'b1);
        m.stop;
        CE = 1'b1;
        repeat (4) @(negedge CLK);
        chk_pins;
        for (int k = 0; k < 6; k++) begin
            if (k == 3) begin
                rst;
                chk_pins;
            end
            rnd = nxt(rnd);
            ext = rnd[3:0];
            for (int r = 0; r < 4; r++) begin
                wr(2'(r), rnd[8*r +: 8]);
                rd(2'(r), 1'b0);
            end
            chk_pins;
            fa = rnd[22:16] ^ 7'(rnd[22:16] == `GX_DEV_ADDR);
            m.start;
            bw({fa, rnd[31]}, 1'b1);
            bw(rnd[15:8], 1'b1);
            m.stop;
        end
        if (exp_q.size() != 0) begin
            err_count++;
            $display("[ERR] %0t bus notes left unanswered", $time);
        end
        results;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge CLK);
        err_count++;
        $display("[ERR] %0t run timed out", $time);
        results;
    end
endmodule : tb
`default_nettype wire

// ---- shared/gpio_expander_params.svh ----
// Purpose: Constants for the four-pin serial port expander
// Assumes: Included by bare name from the package and the design
// Notes:   Definitions only
`ifndef GPIO_EXPANDER_PARAMS_SVH
`define GPIO_EXPANDER_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus addressing and framing
// ----------------------------------------------------------------------
`define GX_DEV_ADDR      7'h41
`define GX_BYTE_BITS     4'h8

// ----------------------------------------------------------------------
// Register indices selected by the command byte
// ----------------------------------------------------------------------
`define GX_REG_INPUT     2'h0
`define GX_REG_OUTPUT    2'h1
`define GX_REG_POLARITY  2'h2
`define GX_REG_DIRECTION 2'h3

// ----------------------------------------------------------------------
// Reset values and unused upper nibbles
// ----------------------------------------------------------------------
`define GX_OUT_RST       4'hF
`define GX_POL_RST       4'h0
`define GX_DIR_RST       4'hF
`define GX_HIGH_ONES     4'hF
`define GX_HIGH_ZEROS    4'h0

`endif

// ---- shared/gpio_expander_pkg.sv ----
// Purpose: Types for the four-pin serial port expander
// Assumes: gpio_expander_params.svh on the include path
// Notes:   State of each clock domain is one packed struct
`include "gpio_expander_params.svh"

package gpio_expander_pkg;

    // ------------------------------------------------------------------
    // Serial bus sequencer, Gray coded along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE  = 3'h2,
        ST_WR_ACK   = 3'h6,
        ST_RD_BYTE  = 3'h7,
        ST_RD_ACK   = 3'h5,
        ST_IGNORE   = 3'h4
    } bus_state_t;

    // ------------------------------------------------------------------
    // Link-clock domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rst_s1;
        logic       rst_s2;
        logic       ce_s1;
        logic       ce_s2;
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_q;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_q;
        logic       ack_s1;
        logic       ack_s2;
        bus_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [1:0] ptr;
        logic       rw;
        logic       first;
        logic       mack;
        logic       sda_oe_n;
        logic       sda_out;
        logic       wr_tgl;
        logic [1:0] wr_idx;
        logic [3:0] wr_dat;
        logic       rd_tgl;
    } link_state_t;

    // ------------------------------------------------------------------
    // System clock domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] inp_s1;
        logic [3:0] inp_s2;
        logic       wtg_s1;
        logic       wtg_s2;
        logic       wtg_q;
        logic       rtg_s1;
        logic       rtg_s2;
        logic       rd_ack_tgl;
        logic [7:0] rd_dat;
        logic [3:0] out_r;
        logic [3:0] pol_r;
        logic [3:0] dir_r;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
    } sys_state_t;

endpackage : gpio_expander_pkg

// ---- src/gpio_expander_i2c.sv ----
// Purpose: Four-pin I/O expander behind a two-wire serial target
// Assumes: LINK_CLK oversamples SCL/SDA; CLK holds registers and pins
// Notes:   Register values cross by toggle handshakes, words held stable
//
// What this block does
// - Pins power up as released inputs
// - Four-bit input, output, polarity, direction registers
// - Written direction bits applied per pin
// - Input captures pins, output register holds drive
// - Polarity bit inverts reported input value
// - Every register readable over the bus
// - Reset restores defaults and idles sequencer
// - Input pins have both drivers off
// - Output pins driven from output register bit
// - SDA falling with SCL high is start
// - Own address acknowledged on ninth pulse
// - SDA change during SCL high is condition
// - SDA rising with SCL high is stop
// - Eight bits then one acknowledge per byte
// - Transmitter releases SDA; acknowledger holds low
// - Every written byte acknowledged
// - On controller NACK, release SDA for stop
// - Respond only to address 0x41
// - Last address bit: 1 read, 0 write
// - First write byte selects register, two bits
// - Selected register kept for later reads
// - Direction 1 input, 0 output
// - Polarity 1 inverts, 0 passes
`include "gpio_expander_params.svh"
`timescale 1ns/10ps
`default_nettype none

module gpio_expander_i2c
    import gpio_expander_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic CE,
    input  wire logic LINK_CLK,
    input  wire logic SCL_IN,
    input  wire logic SDA_IN,
    output var  logic SDA_OUT,
    output var  logic SDA_OE_N,
    input  wire logic PORT_PIN_ZERO_IN,
    output var  logic PORT_PIN_ZERO_OUT,
    output var  logic PORT_PIN_ZERO_OE_N,
    input  wire logic PORT_PIN_ONE_IN,
    output var  logic PORT_PIN_ONE_OUT,
    output var  logic PORT_PIN_ONE_OE_N,
    input  wire logic PORT_PIN_TWO_IN,
    output var  logic PORT_PIN_TWO_OUT,
    output var  logic PORT_PIN_TWO_OE_N,
    input  wire logic PORT_PIN_THREE_IN,
    output var  logic PORT_PIN_THREE_OUT,
    output var  logic PORT_PIN_THREE_OE_N
);

    // ------------------------------------------------------------------
    // State of both domains
    // ------------------------------------------------------------------
    link_state_t l_r;
    link_state_t l_nxt;
    sys_state_t  s_r;
    sys_state_t  s_nxt;
    logic [3:0]  pin_in;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;

    assign pin_in = {PORT_PIN_THREE_IN, PORT_PIN_TWO_IN, PORT_PIN_ONE_IN, PORT_PIN_ZERO_IN};

    // Edge and condition detection on the second synchroniser stage
    assign scl_rise   = l_r.scl_s2 & ~l_r.scl_q;
    assign scl_fall   = ~l_r.scl_s2 & l_r.scl_q;
    assign start_cond = l_r.scl_s2 & l_r.scl_q & l_r.sda_q & ~l_r.sda_s2;
    assign stop_cond  = l_r.scl_s2 & l_r.scl_q & ~l_r.sda_q & l_r.sda_s2;

    // ------------------------------------------------------------------
    // Link domain: serial target sequencer
    // ------------------------------------------------------------------
    // Reset and enable are resynchronised here; sequencer idles on reset
    always_comb begin
        l_nxt        = l_r;
        l_nxt.rst_s1 = RSTN;
        l_nxt.rst_s2 = l_r.rst_s1;
        l_nxt.ce_s1  = CE;
        l_nxt.ce_s2  = l_r.ce_s1;
        if (!l_r.rst_s2) begin
            l_nxt.state    = ST_IDLE;
            // Synchronisers park at idle bus levels so release sees no false edge
            l_nxt.scl_s1   = 1'b1;
            l_nxt.scl_s2   = 1'b1;
            l_nxt.scl_q    = 1'b1;
            l_nxt.sda_s1   = 1'b1;
            l_nxt.sda_s2   = 1'b1;
            l_nxt.sda_q    = 1'b1;
            l_nxt.ack_s1   = 1'b0;
            l_nxt.ack_s2   = 1'b0;
            l_nxt.bit_cnt  = 4'h0;
            l_nxt.shift    = 8'h00;
            l_nxt.ptr      = `GX_REG_INPUT;
            l_nxt.rw       = 1'b0;
            l_nxt.first    = 1'b0;
            l_nxt.mack     = 1'b0;
            l_nxt.sda_oe_n = 1'b1;
            l_nxt.sda_out  = 1'b0;
            l_nxt.wr_tgl   = 1'b0;
            l_nxt.wr_idx   = `GX_REG_INPUT;
            l_nxt.wr_dat   = 4'h0;
            l_nxt.rd_tgl   = 1'b0;
        end else if (l_r.ce_s2) begin
            l_nxt.scl_s1 = SCL_IN;
            l_nxt.scl_s2 = l_r.scl_s1;
            l_nxt.scl_q  = l_r.scl_s2;
            l_nxt.sda_s1 = SDA_IN;
            l_nxt.sda_s2 = l_r.sda_s1;
            l_nxt.sda_q  = l_r.sda_s2;
            l_nxt.ack_s1 = s_r.rd_ack_tgl;
            l_nxt.ack_s2 = l_r.ack_s1;
            if (start_cond) begin
                // Repeated start accepted from any state
                l_nxt.state    = ST_ADDR;
                l_nxt.bit_cnt  = 4'h0;
                l_nxt.sda_oe_n = 1'b1;
            end else if (stop_cond) begin
                l_nxt.state    = ST_IDLE;
                l_nxt.sda_oe_n = 1'b1;
            end else if (scl_rise) begin
                unique case (l_r.state)
                    ST_ADDR, ST_WR_BYTE: begin
                        l_nxt.shift   = {l_r.shift[6:0], l_r.sda_s2};
                        l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
                    end
                    ST_RD_BYTE: begin
                        l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
                    end
                    ST_RD_ACK: begin
                        l_nxt.mack = ~l_r.sda_s2;
                    end
                    ST_IDLE, ST_ADDR_ACK, ST_WR_ACK, ST_IGNORE: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (l_r.state)
                    ST_ADDR: begin
                        if (l_r.bit_cnt == `GX_BYTE_BITS) begin
                            if (l_r.shift[7:1] == `GX_DEV_ADDR) begin
                                l_nxt.state    = ST_ADDR_ACK;
                                l_nxt.sda_oe_n = 1'b0;
                                l_nxt.rw       = l_r.shift[0];
                                // Fetch early so the word has crossed by the ack end
                                l_nxt.rd_tgl   = l_r.rd_tgl ^ l_r.shift[0];
                            end else begin
                                l_nxt.state = ST_IGNORE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        l_nxt.bit_cnt = 4'h0;
                        if (l_r.rw) begin
                            l_nxt.state    = ST_RD_BYTE;
                            l_nxt.shift    = s_r.rd_dat;
                            l_nxt.sda_oe_n = s_r.rd_dat[7];
                        end else begin
                            l_nxt.state    = ST_WR_BYTE;
                            l_nxt.sda_oe_n = 1'b1;
                            l_nxt.first    = 1'b1;
                        end
                    end
                    ST_WR_BYTE: begin
                        if (l_r.bit_cnt == `GX_BYTE_BITS) begin
                            l_nxt.state    = ST_WR_ACK;
                            l_nxt.sda_oe_n = 1'b0;
                            if (l_r.first) begin
                                l_nxt.ptr = l_r.shift[1:0];
                            end else begin
                                l_nxt.wr_idx = l_r.ptr;
                                l_nxt.wr_dat = l_r.shift[3:0];
                                l_nxt.wr_tgl = ~l_r.wr_tgl;
                            end
                        end
                    end
                    ST_WR_ACK: begin
                        l_nxt.state    = ST_WR_BYTE;
                        l_nxt.sda_oe_n = 1'b1;
                        l_nxt.bit_cnt  = 4'h0;
                        l_nxt.first    = 1'b0;
                    end
                    ST_RD_BYTE: begin
                        if (l_r.bit_cnt == `GX_BYTE_BITS) begin
                            l_nxt.state    = ST_RD_ACK;
                            l_nxt.sda_oe_n = 1'b1;
                            l_nxt.rd_tgl   = ~l_r.rd_tgl;
                        end else begin
                            l_nxt.shift    = {l_r.shift[6:0], 1'b0};
                            l_nxt.sda_oe_n = l_r.shift[6];
                        end
                    end
                    ST_RD_ACK: begin
                        l_nxt.bit_cnt = 4'h0;
                        if (l_r.mack) begin
                            l_nxt.state    = ST_RD_BYTE;
                            l_nxt.shift    = s_r.rd_dat;
                            l_nxt.sda_oe_n = s_r.rd_dat[7];
                        end else begin
                            l_nxt.state    = ST_IGNORE;
                            l_nxt.sda_oe_n = 1'b1;
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                    end
                endcase
            end
        end
    end

    // Link register stage
    always_ff @(posedge LINK_CLK) begin
        l_r <= l_nxt;
    end

    // ------------------------------------------------------------------
    // System domain: registers and pin drivers
    // ------------------------------------------------------------------
    // Crossed words are read only after their toggle has been resynchronised
    always_comb begin
        s_nxt = s_r;
        if (!RSTN) begin
            // Toggle synchronisers match the link toggles' reset, no stray transfer
            s_nxt.wtg_s1     = 1'b0;
            s_nxt.wtg_s2     = 1'b0;
            s_nxt.wtg_q      = 1'b0;
            s_nxt.rtg_s1     = 1'b0;
            s_nxt.rtg_s2     = 1'b0;
            s_nxt.rd_ack_tgl = 1'b0;
            s_nxt.rd_dat     = 8'h00;
            s_nxt.out_r      = `GX_OUT_RST;
            s_nxt.pol_r      = `GX_POL_RST;
            s_nxt.dir_r      = `GX_DIR_RST;
            s_nxt.pin_out    = `GX_OUT_RST;
            s_nxt.pin_oe_n   = `GX_DIR_RST;
        end else if (CE) begin
            s_nxt.inp_s1 = pin_in;
            s_nxt.inp_s2 = s_r.inp_s1;
            s_nxt.wtg_s1 = l_r.wr_tgl;
            s_nxt.wtg_s2 = s_r.wtg_s1;
            s_nxt.wtg_q  = s_r.wtg_s2;
            s_nxt.rtg_s1 = l_r.rd_tgl;
            s_nxt.rtg_s2 = s_r.rtg_s1;
            // Writes to the input register are dropped
            if (s_r.wtg_s2 != s_r.wtg_q) begin
                unique case (l_r.wr_idx)
                    `GX_REG_INPUT:     s_nxt.out_r = s_r.out_r;
                    `GX_REG_OUTPUT:    s_nxt.out_r = l_r.wr_dat;
                    `GX_REG_POLARITY:  s_nxt.pol_r = l_r.wr_dat;
                    `GX_REG_DIRECTION: s_nxt.dir_r = l_r.wr_dat;
                endcase
            end
            // Read snapshot; inputs sampled at request time
            if (s_r.rtg_s2 != s_r.rd_ack_tgl) begin
                s_nxt.rd_ack_tgl = s_r.rtg_s2;
                unique case (l_r.ptr)
                    `GX_REG_INPUT:     s_nxt.rd_dat = {`GX_HIGH_ONES, s_r.inp_s2 ^ s_r.pol_r};
                    `GX_REG_OUTPUT:    s_nxt.rd_dat = {`GX_HIGH_ONES, s_r.out_r};
                    `GX_REG_POLARITY:  s_nxt.rd_dat = {`GX_HIGH_ZEROS, s_r.pol_r};
                    `GX_REG_DIRECTION: s_nxt.rd_dat = {`GX_HIGH_ONES, s_r.dir_r};
                endcase
            end
            // Direction 1 releases both drivers, 0 drives the output bit
            s_nxt.pin_oe_n = s_r.dir_r;
            s_nxt.pin_out  = s_r.out_r;
        end
    end

    // System register stage
    always_ff @(posedge CLK) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign SDA_OUT             = l_r.sda_out;
    assign SDA_OE_N            = l_r.sda_oe_n;
    assign PORT_PIN_ZERO_OUT   = s_r.pin_out[0];
    assign PORT_PIN_ZERO_OE_N  = s_r.pin_oe_n[0];
    assign PORT_PIN_ONE_OUT    = s_r.pin_out[1];
    assign PORT_PIN_ONE_OE_N   = s_r.pin_oe_n[1];
    assign PORT_PIN_TWO_OUT    = s_r.pin_out[2];
    assign PORT_PIN_TWO_OE_N   = s_r.pin_oe_n[2];
    assign PORT_PIN_THREE_OUT  = s_r.pin_out[3];
    assign PORT_PIN_THREE_OE_N = s_r.pin_oe_n[3];

endmodule : gpio_expander_i2c

`default_nettype wire
